// File: rtl/rule_matcher_cfg.svh
// Register offsets, field positions, reset values and protocol numbers of the rule matcher
`ifndef RULE_MATCHER_CFG_SVH
`define RULE_MATCHER_CFG_SVH

// Byte offsets on the APB bus
`define OFF_CTRL       8'h00
`define OFF_VALUES     8'h04
`define OFF_SRC_WORD   8'h08
`define OFF_SRC_MASK   8'h0C
`define OFF_STATUS     8'h10
`define OFF_FRAME_CNT  8'h14
`define OFF_HIT_CNT    8'h18

// Control register fields
`define CTRL_W         9
`define ENABLE_BIT     0
`define NH_SEL_LSB     1
`define NH_SEL_MSB     3
`define HOP_SEL_LSB    4
`define HOP_SEL_MSB    5
`define SRC_EN_BIT     6
`define TYPE_EN_BIT    7
`define CODE_EN_BIT    8

// Value register fields
`define VALUES_W       24
`define NH_VAL_LSB     0
`define NH_VAL_MSB     7
`define TYPE_VAL_LSB   8
`define TYPE_VAL_MSB   15
`define CODE_VAL_LSB   16
`define CODE_VAL_MSB   23

// Status register width
`define STATUS_W       7

// Reset values
`define CTRL_RST       9'h000
`define VALUES_RST     24'h000000
`define SRC_WORD_RST   32'h00000000
`define SRC_MASK_RST   32'hFFFFFFFF

// Upper-layer protocol numbers carried in the next-header field
`define PROTO_ICMPV6   8'h3A
`define PROTO_UDP      8'h11
`define PROTO_TCP      8'h06

`endif

// File: rtl/rule_matcher_pkg.sv
// Types shared by the rule matcher files
package rule_matcher_pkg;

    // Next-header selector, encoded 0 to 4 in this order
    typedef enum logic [2:0] {
        NH_ANY,
        NH_SPECIFIC,
        NH_ICMP,
        NH_UDP,
        NH_TCP
    } nh_sel_t;

    // Hop-limit selector, encoded 0 to 2 in this order
    typedef enum logic [1:0] {
        HOP_ANY,
        HOP_ZERO,
        HOP_NONZERO
    } hop_sel_t;

endpackage

// File: rtl/src_cmp_if.sv
// Carrier between the matcher and its masked source-address comparator
`timescale 1ns/1ps
interface src_cmp_if;
    logic [31:0] frame_word;
    logic [31:0] cfg_word;
    logic [31:0] cfg_mask;
    logic        hit;

    modport matcher (output frame_word, output cfg_word, output cfg_mask, input hit);
    modport cmp     (input frame_word, input cfg_word, input cfg_mask, output hit);
endinterface

// File: rtl/src_mask_cmp.sv
// Masked comparison of the low source-address word against the configured word
`timescale 1ns/1ps
module src_mask_cmp (
    src_cmp_if.cmp cmp_bus
);
    logic [31:0] bit_miss;

    // A zero mask bit can never produce a miss, so it is don't-care
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1)
        begin : g_bit
            assign bit_miss[i] = cmp_bus.cfg_mask[i]
                               & (cmp_bus.cfg_word[i] ^ cmp_bus.frame_word[i]);
        end
    endgenerate

    // Same as (word & mask) == (addr & mask)
    assign cmp_bus.hit = ~|bit_miss;
endmodule

// File: rtl/ipv6_icmp_rule_matcher.sv
// One IPv6/ICMP access-control rule entry with its APB register file
`timescale 1ns/1ps
`include "rule_matcher_cfg.svh"

// How it works
// - Next-header selector at any: the next-header field is ignored.
// - Specific selector: next-header must equal the configured 8-bit value.
// - ICMP selector: only ICMPv6 frames match; ICMP type and code checks apply.
// - UDP selector: only frames carrying UDP match.
// - TCP selector: only frames carrying TCP match.
// - Source selector at any: the source address is ignored.
// - Source filtering looks at the low 32 address bits only.
// - A zero mask bit makes that address bit don't-care.
// - Hit when configured word and mask equals frame word and mask.
// - Hop selector zero: frames with hop limit above zero never match.
// - Hop selector non-zero: hop above zero matches; any allows all values.
// - ICMP type selector at any: the type field is ignored.
// - Specific type: ICMP type must equal the configured 8-bit value.
// - ICMP code selector at any: the code field is ignored.
// - Specific code: ICMP code must equal the configured 8-bit value.
module ipv6_icmp_rule_matcher (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    input  wire logic        hdr_valid,
    input  wire logic [7:0]  hdr_next_header,
    input  wire logic [31:0] hdr_src_low,
    input  wire logic [7:0]  hdr_hop_limit,
    input  wire logic [7:0]  hdr_icmp_type,
    input  wire logic [7:0]  hdr_icmp_code,
    output wire logic        match_valid,
    output wire logic        match_hit
);

    // Configuration registers
    logic [`CTRL_W-1:0]   ctrl_q;
    logic [`VALUES_W-1:0] values_q;
    logic [31:0]          src_word_q;
    logic [31:0]          src_mask_q;

    // Observed state
    logic [`STATUS_W-1:0] status_q;
    logic                 frame_seen_q;
    logic [31:0]          frame_cnt_q;
    logic [31:0]          frame_cnt_d;
    logic [31:0]          hit_cnt_q;
    logic [31:0]          hit_cnt_d;

    // Bus answer registers
    logic [31:0]          prdata_q;
    logic                 pready_q;
    logic                 pslverr_q;

    // Match result registers
    logic                 match_valid_q;
    logic                 match_hit_q;

    // Decoded configuration
    rule_matcher_pkg::nh_sel_t  nh_sel;
    rule_matcher_pkg::hop_sel_t hop_sel;
    wire logic       entry_en;
    wire logic       src_en;
    wire logic       type_en;
    wire logic       code_en;
    wire logic [7:0] nh_val;
    wire logic [7:0] type_val;
    wire logic [7:0] code_val;

    // Per-criterion results
    logic            nh_ok;
    logic            hop_ok;
    wire logic       icmp_applies;
    wire logic       src_ok;
    wire logic       type_ok;
    wire logic       code_ok;
    wire logic       hit_now;

    // Bus decode
    wire logic        setup_phase;
    wire logic        access_done;
    wire logic        sel_ctrl;
    wire logic        sel_values;
    wire logic        sel_src_word;
    wire logic        sel_src_mask;
    wire logic        sel_status;
    wire logic        sel_frame_cnt;
    wire logic        sel_hit_cnt;
    wire logic        addr_mapped;
    wire logic        wr_ok;
    wire logic        cnt_clear;
    wire logic [31:0] wmask;
    wire logic [31:0] ctrl_wr;
    wire logic [31:0] values_wr;
    wire logic [31:0] src_word_wr;
    wire logic [31:0] src_mask_wr;
    wire logic [31:0] rd_mux;

    src_cmp_if src_bus ();

    src_mask_cmp u_src_cmp (
        .cmp_bus (src_bus.cmp)
    );

    // Configuration fields
    // Illegal selector codes are kept and refused by the criteria below

    assign nh_sel   = rule_matcher_pkg::nh_sel_t'(ctrl_q[`NH_SEL_MSB:`NH_SEL_LSB]);
    assign hop_sel  = rule_matcher_pkg::hop_sel_t'(ctrl_q[`HOP_SEL_MSB:`HOP_SEL_LSB]);
    assign entry_en = ctrl_q[`ENABLE_BIT];
    assign src_en   = ctrl_q[`SRC_EN_BIT];
    assign type_en  = ctrl_q[`TYPE_EN_BIT];
    assign code_en  = ctrl_q[`CODE_EN_BIT];
    assign nh_val   = values_q[`NH_VAL_MSB:`NH_VAL_LSB];
    assign type_val = values_q[`TYPE_VAL_MSB:`TYPE_VAL_LSB];
    assign code_val = values_q[`CODE_VAL_MSB:`CODE_VAL_LSB];

    // Next-header criterion
    // Protocol numbers are fixed; only the specific mode reads the value

    always_comb
    begin
        unique case (nh_sel)
            rule_matcher_pkg::NH_ANY:      nh_ok = 1'b1;
            rule_matcher_pkg::NH_SPECIFIC: nh_ok = (hdr_next_header == nh_val);
            rule_matcher_pkg::NH_ICMP:     nh_ok = (hdr_next_header == `PROTO_ICMPV6);
            rule_matcher_pkg::NH_UDP:      nh_ok = (hdr_next_header == `PROTO_UDP);
            rule_matcher_pkg::NH_TCP:      nh_ok = (hdr_next_header == `PROTO_TCP);
            // Codes 5 to 7 are illegal; refusing every frame is the safe side
            default:                       nh_ok = 1'b0;
        endcase
    end

    assign icmp_applies = (nh_sel == rule_matcher_pkg::NH_ICMP);

    // Source-address criterion
    // The upper 96 address bits never reach this block

    assign src_bus.frame_word = hdr_src_low;
    assign src_bus.cfg_word   = src_word_q;
    assign src_bus.cfg_mask   = src_mask_q;

    assign src_ok = ~src_en | src_bus.hit;

    // Hop-limit criterion
    // Only zero against non-zero matters, so no value is configured

    always_comb
    begin
        unique case (hop_sel)
            rule_matcher_pkg::HOP_ANY:     hop_ok = 1'b1;
            rule_matcher_pkg::HOP_ZERO:    hop_ok = (hdr_hop_limit == 8'h00);
            rule_matcher_pkg::HOP_NONZERO: hop_ok = (hdr_hop_limit != 8'h00);
            // Code 3 is illegal and matches nothing
            default:                       hop_ok = 1'b0;
        endcase
    end

    // ICMP criteria
    // Only meaningful when the ICMP selector is chosen

    assign type_ok = ~icmp_applies | ~type_en | (hdr_icmp_type == type_val);

    assign code_ok = ~icmp_applies | ~code_en | (hdr_icmp_code == code_val);

    assign hit_now = entry_en & nh_ok & src_ok & hop_ok & type_ok & code_ok;

    // Match result
    // One cycle after the header strobe, straight from flops

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            match_valid_q <= 1'b0;
            match_hit_q   <= 1'b0;
        end
        else
        begin
            match_valid_q <= hdr_valid;
            match_hit_q   <= hdr_valid & hit_now;
        end
    end

    assign match_valid = match_valid_q;
    assign match_hit   = match_hit_q;

    // Criterion snapshot of the latest frame, for software debugging of the entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_q     <= '0;
            frame_seen_q <= 1'b0;
        end
        else if (hdr_valid)
        begin
            status_q     <= {frame_seen_q, code_ok, type_ok, hop_ok, src_ok, nh_ok, hit_now};
            frame_seen_q <= 1'b1;
        end
    end

    // Frame and hit counters
    // A count in the clearing cycle survives, so no frame is lost

    assign frame_cnt_d = cnt_clear ? {31'h0, hdr_valid}
                                   : frame_cnt_q + {31'h0, hdr_valid};
    assign hit_cnt_d   = cnt_clear ? {31'h0, hdr_valid & hit_now}
                                   : hit_cnt_q + {31'h0, hdr_valid & hit_now};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_cnt_q <= 32'h0;
            hit_cnt_q   <= 32'h0;
        end
        else
        begin
            frame_cnt_q <= frame_cnt_d;
            hit_cnt_q   <= hit_cnt_d;
        end
    end

    // APB slave
    // One access phase after every setup; fixed latency keeps software simple

    assign setup_phase   = psel & ~penable;
    assign access_done   = psel & penable & pready_q;

    assign sel_ctrl      = (paddr == `OFF_CTRL);
    assign sel_values    = (paddr == `OFF_VALUES);
    assign sel_src_word  = (paddr == `OFF_SRC_WORD);
    assign sel_src_mask  = (paddr == `OFF_SRC_MASK);
    assign sel_status    = (paddr == `OFF_STATUS);
    assign sel_frame_cnt = (paddr == `OFF_FRAME_CNT);
    assign sel_hit_cnt   = (paddr == `OFF_HIT_CNT);
    assign addr_mapped   = sel_ctrl | sel_values | sel_src_word | sel_src_mask
                         | sel_status | sel_frame_cnt | sel_hit_cnt;

    // Writes land only at the edge that completes the access
    assign wr_ok     = access_done & pwrite & addr_mapped;
    assign cnt_clear = wr_ok & sel_frame_cnt;

    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1)
        begin : g_lane
            assign wmask[8*b+7:8*b] = {8{pstrb[b]}};
        end
    endgenerate

    assign ctrl_wr     = ({{(32-`CTRL_W){1'b0}}, ctrl_q} & ~wmask) | (pwdata & wmask);
    assign values_wr   = ({{(32-`VALUES_W){1'b0}}, values_q} & ~wmask) | (pwdata & wmask);
    assign src_word_wr = (src_word_q & ~wmask) | (pwdata & wmask);
    assign src_mask_wr = (src_mask_q & ~wmask) | (pwdata & wmask);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q     <= `CTRL_RST;
            values_q   <= `VALUES_RST;
            src_word_q <= `SRC_WORD_RST;
            src_mask_q <= `SRC_MASK_RST;
        end
        else if (wr_ok)
        begin
            if (sel_ctrl)
                ctrl_q <= ctrl_wr[`CTRL_W-1:0];
            if (sel_values)
                values_q <= values_wr[`VALUES_W-1:0];
            if (sel_src_word)
                src_word_q <= src_word_wr;
            if (sel_src_mask)
                src_mask_q <= src_mask_wr;
        end
    end

    // Reserved bits read as zero
    assign rd_mux =
          ({32{sel_ctrl}}      & {{(32-`CTRL_W){1'b0}}, ctrl_q})
        | ({32{sel_values}}    & {{(32-`VALUES_W){1'b0}}, values_q})
        | ({32{sel_src_word}}  & src_word_q)
        | ({32{sel_src_mask}}  & src_mask_q)
        | ({32{sel_status}}    & {{(32-`STATUS_W){1'b0}}, status_q})
        | ({32{sel_frame_cnt}} & frame_cnt_q)
        | ({32{sel_hit_cnt}}   & hit_cnt_q);

    // Read data is captured in the setup cycle so it leaves a flop; a counter
    // that moves during the access phase shows its setup-cycle value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup_phase;
            pslverr_q <= setup_phase & ~addr_mapped;
            if (setup_phase)
                prdata_q <= (pwrite ? 32'h0 : rd_mux);
            else if (access_done)
                prdata_q <= 32'h0;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

endmodule

// File: bench/rule_match_monitor.sv
// Port-level checker for the rule matcher
`timescale 1ns/1ps
module rule_match_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        hdr_valid,
    input wire logic        match_valid,
    input wire logic        match_hit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_unaligned: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned access not refused");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_match_follows: assert property (hdr_valid |=> match_valid)
        else $error("frame not judged");
    a_match_cause: assert property (match_valid |-> $past(hdr_valid))
        else $error("verdict without frame");
    a_hit_qualified: assert property (match_hit |-> match_valid)
        else $error("hit without verdict");
endmodule

bind ipv6_icmp_rule_matcher rule_match_monitor i_rule_match_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid),
    .match_valid(match_valid), .match_hit(match_hit));

// File: bench/hdr_source.sv
// Model of the upstream header parser
`timescale 1ns/1ps
module hdr_source (
    input  wire logic        pclk,
    output logic             hdr_valid,
    output logic [55:0]      hdr_fields
);
    initial
    begin
        hdr_valid = 1'b0;
        hdr_fields = '0;
    end

    task automatic send(input logic [55:0] f);
        @(posedge pclk);
        hdr_valid <= 1'b1;
        hdr_fields <= f;
        @(posedge pclk);
        hdr_valid <= 1'b0;
        // Stale fields are inverted so nothing can lean on them
        hdr_fields <= ~f;
    endtask
endmodule

// File: bench/ipv6_icmp_rule_matcher_tb_top.sv
// Self-checking bench for the rule matcher
`timescale 1ns/1ps
`include "rule_matcher_cfg.svh"
module ipv6_icmp_rule_matcher_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, hdr_valid, match_valid, match_hit;
    logic [55:0] f;
    logic [8:0]  c_q = '0;
    logic [23:0] v_q = '0;
    logic [31:0] w_q = '0, m_q = 32'hFFFFFFFF;
    logic [32:0] apb_q[$];
    logic        hit_q[$];
    integer      num_errors = 0, compares = 0, seed = 32'h0C1DD34E, i, k;
    integer      nf = 0, nhit = 0;
    logic [3:0]  strb = 4'hF;

    always #20 pclk = ~pclk;

    ipv6_icmp_rule_matcher i_ipv6_icmp_rule_matcher (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hdr_valid(hdr_valid), .hdr_next_header(f[55:48]), .hdr_src_low(f[47:16]),
        .hdr_hop_limit(f[15:8]), .hdr_icmp_type(f[7:0]), .hdr_icmp_code(f[7:0] ^ 8'h5A),
        .match_valid(match_valid), .match_hit(match_hit));
    hdr_source i_hdr_source (.pclk(pclk), .hdr_valid(hdr_valid), .hdr_fields(f));

    task automatic check_bus(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t bus got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_hit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t hit got %b expected %b", $time, got, exp);
        end
    endtask

    // Notes hold error flag and full read word; a write expects an idle zero word
    always @(posedge pclk)
    begin
        if (pready === 1'b1)
            check_bus({pslverr, prdata}, apb_q.pop_front());
        if (match_valid === 1'b1)
            check_hit(match_hit, hit_q.pop_front());
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic err);
        apb_q.push_back({err, w ? 32'h0 : e});
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a == `OFF_CTRL) c_q = d[8:0];
        if (a == `OFF_VALUES) v_q = d[23:0];
        if (a == `OFF_SRC_WORD) w_q = d;
        if (a == `OFF_SRC_MASK) m_q = d;
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask

    // Reference verdict kept from the bench's own copy of the settings
    task automatic frame(input logic [7:0] nh, input logic [31:0] s, input logic [7:0] h,
                         input logic [7:0] t);
        logic n_ok, h_ok, i_ok, e;
        case (c_q[3:1])
            3'd0: n_ok = 1'b1;
            3'd1: n_ok = nh == v_q[7:0];
            3'd2: n_ok = nh == `PROTO_ICMPV6;
            3'd3: n_ok = nh == `PROTO_UDP;
            3'd4: n_ok = nh == `PROTO_TCP;
            default: n_ok = 1'b0;
        endcase
        h_ok = c_q[5:4] == 2'd0 || (c_q[5:4] == 2'd1 && h == 0) || (c_q[5:4] == 2'd2 && h != 0);
        i_ok = c_q[3:1] != 3'd2 || ((!c_q[7] || t == v_q[15:8])
               && (!c_q[8] || (t ^ 8'h5A) == v_q[23:16]));
        e = c_q[0] && n_ok && h_ok && i_ok && (!c_q[6] || ((s ^ w_q) & m_q) == 0);
        hit_q.push_back(e);
        nf++;
        if (e)
            nhit++;
        i_hdr_source.send({nh, s, h, t});
    endtask

    task automatic tally_and_finish;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0 && apb_q.size() == 0 && hit_q.size() == 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        tally_and_finish;
    end

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OFF_CTRL, 0, 32'h0, 0);
        apb(0, `OFF_SRC_MASK, 0, 32'hFFFFFFFF, 0);
        apb(0, `OFF_SRC_WORD, 0, 32'h0, 0);
        apb(0, 8'h1C, 0, 32'h0, 1);
        apb(1, 8'h06, 32'hFFFFFFFF, 32'h0, 1);
        for (k = 0; k < 6; k++)
        begin
            wr(`OFF_VALUES, $random(seed));
            wr(`OFF_CTRL, {k[2:0], 1'b1});
            frame(`PROTO_ICMPV6, $random(seed), $random(seed), $random(seed));
            frame(`PROTO_UDP, $random(seed), $random(seed), $random(seed));
            frame(`PROTO_TCP, $random(seed), $random(seed), $random(seed));
            frame(v_q[7:0], $random(seed), $random(seed), $random(seed));
        end
        // mask with a don't-care low bit
        wr(`OFF_SRC_WORD, $random(seed));
        wr(`OFF_SRC_MASK, 32'hFFFFFFFE);
        for (k = 0; k < 2; k++)
        begin
            wr(`OFF_CTRL, {k[0], 6'h01});
            for (i = 0; i < 3; i++)
                frame($random(seed), w_q ^ i, $random(seed), $random(seed));
        end
        for (k = 0; k < 4; k++)
        begin
            wr(`OFF_CTRL, {k[1:0], 4'h1});
            frame(0, 0, 8'h00, 0);
            frame(0, 0, 8'h01, 0);
            frame(0, 0, 8'hFF, 0);
        end
        // type and code filters under ICMP
        wr(`OFF_VALUES, {8'h5A ^ 8'h81, 8'h81, 8'h00});
        for (k = 0; k < 4; k++)
        begin
            wr(`OFF_CTRL, {k[1:0], 7'h05});
            frame(`PROTO_ICMPV6, 0, 1, 8'h81);
            frame(`PROTO_ICMPV6, 0, 1, 8'h80);
        end
        wr(`OFF_CTRL, 32'h0);
        frame(`PROTO_ICMPV6, 0, 1, 8'h81);
        // Snapshot of the latest frame, the counters, and a clear of both by a frame-counter write
        apb(0, `OFF_STATUS, 0, 32'h0000007E, 0);
        apb(0, `OFF_FRAME_CNT, 0, nf, 0);
        apb(0, `OFF_HIT_CNT, 0, nhit, 0);
        apb(1, `OFF_HIT_CNT, 32'h0, 32'h0, 0);
        apb(0, `OFF_HIT_CNT, 0, nhit, 0);
        apb(1, `OFF_FRAME_CNT, 32'h0, 32'h0, 0);
        apb(0, `OFF_FRAME_CNT, 0, 32'h0, 0);
        apb(0, `OFF_HIT_CNT, 0, 32'h0, 0);
        // Readback of the settings, then a single-byte write to the source word
        apb(0, `OFF_CTRL, 0, {23'h0, c_q}, 0);
        apb(0, `OFF_VALUES, 0, {8'h00, v_q}, 0);
        apb(0, `OFF_SRC_MASK, 0, m_q, 0);
        strb <= 4'h2;
        apb(1, `OFF_SRC_WORD, 32'hFFFFFFFF, 32'h0, 0);
        strb <= 4'hF;
        apb(0, `OFF_SRC_WORD, 0, w_q | 32'h0000FF00, 0);
        repeat (4) @(posedge pclk);
        tally_and_finish;
    end
endmodule
